// ### isrp_pkg.sv
// shared constants and types of the serial register port
`default_nettype none
package isrp_pkg;
    // write address of the main map when the strap is low; strap sets bit 1
    localparam logic [7:0] DEV_ADDR_BASE = 8'h40;
    // bit position of the address that the strap pin controls
    localparam int DEV_ADDR_SEL_BIT = 1;
    // sub map selection register and its field
    localparam logic [7:0] SUBMAP_SEL_ADDR = 8'h0e;
    localparam int SUBMAP_LSB = 5;
    localparam logic [1:0] SUBMAP_RESET = 2'h0;
    // field codes of the sub map selection
    localparam logic [1:0] SUBMAP_USER = 2'h0;
    localparam logic [1:0] SUBMAP_INTR = 2'h1;
    localparam logic [1:0] SUBMAP_USER2 = 2'h2;
    // contrast enhancement control register (second user sub map)
    localparam logic [7:0] CONTRAST_CTRL_ADDR = 8'h80;
    localparam int CONTRAST_BIT = 7;
    localparam logic CONTRAST_RESET = 1'b0;
    // highest valid subaddress of every sub map
    localparam logic [7:0] LAST_SUBADDR = 8'h9f;
    // number of sub maps that hold storage
    localparam int MAP_COUNT = 3;
    // idle levels of the two bus lines
    localparam logic BUS_IDLE_LEVEL = 1'b1;

    // protocol engine states
    typedef enum logic [3:0] {
        ST_ADDR,
        ST_ADDR_ACK,
        ST_SUB,
        ST_SUB_ACK,
        ST_WDATA,
        ST_WACK,
        ST_RDATA,
        ST_RACK,
        ST_IDLE
    } isrp_state_t;
endpackage : isrp_pkg
`default_nettype wire

// ### isrp_if.sv
// carrier between the protocol engine and the register store
`default_nettype none
interface isrp_if;
    logic wr_en; // write strobe, sampled on rising serial clock
    logic [7:0] wr_addr; // subaddress of the write
    logic [7:0] wr_data; // byte to store
    logic [7:0] rd_addr; // subaddress to read, already clamped
    logic [7:0] rd_data; // combinational read data
    logic [1:0] submap; // active sub map
    logic boost; // contrast enhancement enable

    // engine side
    modport eng (
        output wr_en,
        output wr_addr,
        output wr_data,
        output rd_addr,
        input rd_data,
        input submap,
        input boost
    );
    // register store side
    modport regs (
        input wr_en,
        input wr_addr,
        input wr_data,
        input rd_addr,
        output rd_data,
        output submap,
        output boost
    );
endinterface : isrp_if
`default_nettype wire

// ### isrp_sync.sv
// three-stage synchroniser with agreement filter
`default_nettype none
module isrp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // all stages of the chain plus the accepted value
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } isrp_sync_t;

    isrp_sync_t st_reg;
    isrp_sync_t st_next;
    logic [W-1:0] agree; // per bit, second and third stage match

    // s1 feeds only s2; a bit is accepted once s2 and s3 agree
    always_comb begin
        st_next = st_reg;
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        agree = ~(st_reg.s2 ^ st_reg.s3);
        st_next.q = (st_reg.s3 & agree) | (st_reg.q & ~agree);
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{s1: RST, s2: RST, s3: RST, q: RST};
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.q;
endmodule : isrp_sync
`default_nettype wire

// ### isrp_regfile.sv
// register store of the three sub maps, on the serial clock
`default_nettype none
module isrp_regfile (
    input wire logic scl_clk,
    input wire logic rst_n,
    isrp_if.regs bus
);
    // control registers that steer the rest of the chip
    typedef struct packed {
        logic [1:0] submap; // selected sub map
        logic boost; // contrast enhancement on
    } isrp_regs_t;

    isrp_regs_t r_reg;
    isrp_regs_t r_next;
    logic [7:0] mem [0:isrp_pkg::MAP_COUNT-1][0:isrp_pkg::LAST_SUBADDR]; // plain storage
    logic [1:0] wr_map; // storage bank of the write
    logic [1:0] rd_map; // storage bank of the read
    logic is_sel_wr; // write hits the selection register
    logic is_ctl_wr; // write hits the contrast register

    // bank index; the undefined code 11 falls back to the user map
    function automatic logic [1:0] bank(input logic [1:0] sm);
        bank = (sm == isrp_pkg::SUBMAP_INTR || sm == isrp_pkg::SUBMAP_USER2) ? sm : 2'h0;
    endfunction : bank

    // decode and next value of the control registers
    always_comb begin
        r_next = r_reg;
        wr_map = bank(r_reg.submap);
        rd_map = bank(r_reg.submap);
        is_sel_wr = bus.wr_en && bus.wr_addr == isrp_pkg::SUBMAP_SEL_ADDR;
        is_ctl_wr = bus.wr_en && r_reg.submap == isrp_pkg::SUBMAP_USER2
            && bus.wr_addr == isrp_pkg::CONTRAST_CTRL_ADDR;
        if (is_sel_wr) begin
            r_next.submap = bus.wr_data[isrp_pkg::SUBMAP_LSB +: 2];
        end
        if (is_ctl_wr) begin
            r_next.boost = bus.wr_data[isrp_pkg::CONTRAST_BIT];
        end
        // reserved bits of both special registers read as zero
        if (bus.rd_addr == isrp_pkg::SUBMAP_SEL_ADDR) begin
            bus.rd_data = {1'b0, r_reg.submap, 5'h00};
        end else if (r_reg.submap == isrp_pkg::SUBMAP_USER2
            && bus.rd_addr == isrp_pkg::CONTRAST_CTRL_ADDR) begin
            bus.rd_data = {r_reg.boost, 7'h00};
        end else begin
            bus.rd_data = mem[rd_map][bus.rd_addr];
        end
    end

    // control registers reset with the chip, not with each frame
    always_ff @(posedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '{submap: isrp_pkg::SUBMAP_RESET, boost: isrp_pkg::CONTRAST_RESET};
        end else begin
            r_reg <= r_next;
        end
    end

    // plain storage has no reset, it only holds what software wrote
    always_ff @(posedge scl_clk) begin
        if (bus.wr_en && !is_sel_wr && !is_ctl_wr) begin
            mem[wr_map][bus.wr_addr] <= bus.wr_data;
        end
    end

    assign bus.submap = r_reg.submap;
    assign bus.boost = r_reg.boost;
endmodule : isrp_regfile
`default_nettype wire

// ### isrp_top.sv
// serial register port: start/stop watch, protocol engine, outputs
// Summary of operation
// - strap picks write address 0x40 or 0x42
// - address bit 0 one means read
// - data falling while clock high starts
// - eight address bits shift in, MSB first
// - own address acknowledged on ninth pulse
// - foreign address: release bus, wait idle
// - first byte address, second byte subaddress
// - pointer advances after every data byte, reads stop at top
// - stray start restarts the frame, stray stop forces idle
// - bad subaddress: no acknowledge, go idle
// - reads past top repeat highest register
// - writes past top: discard, nack, idle
// - 0x40 to submap_select_reg enters second map
// - contrast boost off at reset, contrast_enhance_ctrl enables
// - bits 6:5 of submap_select_reg select map
`default_nettype none
module isrp_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_pin,
    input wire logic sda_pin_i,
    input wire logic addr_select_pin,
    output logic sda_pin_o,
    output logic sda_pin_oe,
    output logic contrast_boost,
    output logic [1:0] submap_select
);
    // ---------------- system clock side ----------------

    // watcher state on the system clock
    typedef struct packed {
        logic scl_d; // filtered clock line, previous cycle
        logic sda_d; // filtered data line, previous cycle
        logic frame_rst; // holds the engine in reset between frames
        logic arm; // release pending after a start
        logic sda_lo; // level driven onto the data line, always low
    } isrp_watch_t;

    // engine state on the serial clock rising edge
    typedef struct packed {
        isrp_pkg::isrp_state_t state; // protocol step
        logic [2:0] bit_cnt; // bit within the current byte
        logic [7:0] shreg; // incoming or outgoing byte
        logic rw; // direction of this frame
        logic drv; // pull data low in the coming low phase
    } isrp_eng_t;

    isrp_watch_t w_reg;
    isrp_watch_t w_next;
    isrp_eng_t e_reg;
    isrp_eng_t e_next;
    logic [7:0] ptr_reg; // subaddress pointer, survives repeated starts
    logic [7:0] ptr_next;
    logic oe_reg; // data line pull-down, changes on falling clock
    logic [2:0] pins_s; // filtered clock, data and strap lines
    logic [2:0] regs_s; // sub map and boost brought to this clock
    logic scl_s; // filtered clock line
    logic sda_s; // filtered data line
    logic sel_s; // filtered strap
    logic start_ev; // start seen this cycle
    logic stop_ev; // stop seen this cycle
    logic eng_rst_n; // engine reset, chip reset or between frames
    logic [7:0] byte_in; // byte completed with the bit now on the line
    logic [7:0] own_addr; // own write address
    logic last_bit; // eighth bit of a byte
    logic [7:0] rd_byte; // read data at the pointer

    isrp_if rbus ();

    // both lines and the strap arrive from outside this clock
    isrp_sync #(
        .W(3),
        .RST({1'b0, isrp_pkg::BUS_IDLE_LEVEL, isrp_pkg::BUS_IDLE_LEVEL})
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({addr_select_pin, sda_pin_i, scl_pin}),
        .q(pins_s)
    );

    // register outputs cross from the serial clock; they move rarely,
    // so the agreement filter is applied to each bit on its own
    isrp_sync #(
        .W(3),
        .RST({isrp_pkg::CONTRAST_RESET, isrp_pkg::SUBMAP_RESET})
    ) u_reg_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({rbus.boost, rbus.submap}),
        .q(regs_s)
    );

    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];
    assign sel_s = pins_s[2];

    // line events are judged on filtered samples only
    always_comb begin
        w_next = w_reg;
        w_next.scl_d = scl_s;
        w_next.sda_d = sda_s;
        w_next.sda_lo = 1'b0;
        // start: data falls while clock stays high
        start_ev = scl_s && w_reg.scl_d && w_reg.sda_d && !sda_s;
        // stop: data rises while clock stays high
        stop_ev = scl_s && w_reg.scl_d && !w_reg.sda_d && sda_s;
        // any start or stop puts the engine in reset at once
        if (stop_ev) begin
            // hold the engine idle until the next start
            w_next.frame_rst = 1'b1;
            w_next.arm = 1'b0;
        end else if (start_ev) begin
            // one cycle of reset, then let the frame run
            w_next.frame_rst = 1'b1;
            w_next.arm = 1'b1;
        end else if (w_reg.arm) begin
            w_next.frame_rst = 1'b0;
            w_next.arm = 1'b0;
        end
    end

    // watcher register; the engine sits in reset after chip reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_reg <= '{scl_d: 1'b1, sda_d: 1'b1, frame_rst: 1'b1, arm: 1'b0, sda_lo: 1'b0};
        end else begin
            w_reg <= w_next;
        end
    end

    // the reset is released while the clock line is high, so the first
    // serial edge it meets is a falling one, well after the release
    assign eng_rst_n = rst_n & ~w_reg.frame_rst;

    // ---------------- serial clock side ----------------

    // strap drives bit 1 of the address
    assign own_addr = isrp_pkg::DEV_ADDR_BASE
        | (8'(sel_s) << isrp_pkg::DEV_ADDR_SEL_BIT);

    // protocol engine next state, bits sampled on rising clock
    always_comb begin
        e_next = e_reg;
        ptr_next = ptr_reg;
        // MSB first, the new bit enters at the bottom
        byte_in = {e_reg.shreg[6:0], sda_pin_i};
        last_bit = e_reg.bit_cnt == 3'h7;
        rd_byte = rbus.rd_data;
        rbus.wr_en = 1'b0;
        rbus.wr_addr = ptr_reg;
        rbus.wr_data = byte_in;
        // reads beyond the top keep the highest register
        rbus.rd_addr = (ptr_reg > isrp_pkg::LAST_SUBADDR) ? isrp_pkg::LAST_SUBADDR : ptr_reg;
        case (e_reg.state)
            // address byte after a start
            isrp_pkg::ST_ADDR: begin
                e_next.shreg = byte_in;
                e_next.bit_cnt = 3'(e_reg.bit_cnt + 3'h1);
                if (last_bit) begin
                    // first byte is the device address
                    if (byte_in[7:1] == own_addr[7:1]) begin
                        e_next.rw = byte_in[0];
                        e_next.drv = 1'b1;
                        e_next.state = isrp_pkg::ST_ADDR_ACK;
                    end else begin
                        // not ours, stay off the bus
                        e_next.drv = 1'b0;
                        e_next.state = isrp_pkg::ST_IDLE;
                    end
                end
            end
            // ninth pulse of the address byte
            isrp_pkg::ST_ADDR_ACK: begin
                e_next.bit_cnt = 3'h0;
                if (e_reg.rw) begin
                    // read starts at the pointer left by an earlier write
                    e_next.shreg = rd_byte;
                    e_next.drv = ~rd_byte[7];
                    e_next.state = isrp_pkg::ST_RDATA;
                end else begin
                    e_next.drv = 1'b0;
                    e_next.state = isrp_pkg::ST_SUB;
                end
            end
            isrp_pkg::ST_SUB: begin
                e_next.shreg = byte_in;
                e_next.bit_cnt = 3'(e_reg.bit_cnt + 3'h1);
                if (last_bit) begin
                    if (byte_in <= isrp_pkg::LAST_SUBADDR) begin
                        ptr_next = byte_in;
                        e_next.drv = 1'b1;
                        e_next.state = isrp_pkg::ST_SUB_ACK;
                    end else begin
                        e_next.drv = 1'b0;
                        e_next.state = isrp_pkg::ST_IDLE;
                    end
                end
            end
            // ninth pulse of the subaddress
            isrp_pkg::ST_SUB_ACK: begin
                e_next.drv = 1'b0;
                e_next.bit_cnt = 3'h0;
                e_next.state = isrp_pkg::ST_WDATA;
            end
            // write data bytes
            isrp_pkg::ST_WDATA: begin
                e_next.shreg = byte_in;
                e_next.bit_cnt = 3'(e_reg.bit_cnt + 3'h1);
                if (last_bit) begin
                    if (ptr_reg <= isrp_pkg::LAST_SUBADDR) begin
                        rbus.wr_en = 1'b1;
                        ptr_next = 8'(ptr_reg + 8'h01);
                        e_next.drv = 1'b1;
                        e_next.state = isrp_pkg::ST_WACK;
                    end else begin
                        // past the top: drop, nack, idle
                        e_next.drv = 1'b0;
                        e_next.state = isrp_pkg::ST_IDLE;
                    end
                end
            end
            // ninth pulse of a written byte
            isrp_pkg::ST_WACK: begin
                e_next.drv = 1'b0;
                e_next.bit_cnt = 3'h0;
                e_next.state = isrp_pkg::ST_WDATA;
            end
            // read data bytes; the master samples each bit here
            isrp_pkg::ST_RDATA: begin
                e_next.shreg = {e_reg.shreg[6:0], 1'b0};
                e_next.bit_cnt = 3'(e_reg.bit_cnt + 3'h1);
                if (last_bit) begin
                    // release for the master's acknowledge
                    e_next.drv = 1'b0;
                    e_next.state = isrp_pkg::ST_RACK;
                    // advance, but stop at the top for reads
                    if (ptr_reg < isrp_pkg::LAST_SUBADDR) begin
                        ptr_next = 8'(ptr_reg + 8'h01);
                    end
                end else begin
                    e_next.drv = ~e_reg.shreg[6];
                end
            end
            // ninth pulse of a read byte, driven by the master
            isrp_pkg::ST_RACK: begin
                e_next.bit_cnt = 3'h0;
                if (!sda_pin_i) begin
                    e_next.shreg = rd_byte;
                    e_next.drv = ~rd_byte[7];
                    e_next.state = isrp_pkg::ST_RDATA;
                end else begin
                    e_next.drv = 1'b0;
                    e_next.state = isrp_pkg::ST_IDLE;
                end
            end
            // idle: wait for the next start to reset us
            isrp_pkg::ST_IDLE: begin
                e_next.drv = 1'b0;
            end
            default: begin
                e_next.drv = 1'b0;
                e_next.state = isrp_pkg::ST_IDLE;
            end
        endcase
    end

    // engine register, cleared by every start and held by every stop
    always_ff @(posedge scl_pin or negedge eng_rst_n) begin
        if (!eng_rst_n) begin
            e_reg <= '{state: isrp_pkg::ST_ADDR, bit_cnt: 3'h0, shreg: 8'h00,
                rw: 1'b0, drv: 1'b0};
        end else begin
            e_reg <= e_next;
        end
    end

    // pointer kept across a repeated start so a read can follow a write
    always_ff @(posedge scl_pin or negedge rst_n) begin
        if (!rst_n) begin
            ptr_reg <= 8'h00;
        end else begin
            ptr_reg <= ptr_next;
        end
    end

    // data line changes only on the falling clock edge
    always_ff @(negedge scl_pin or negedge eng_rst_n) begin
        if (!eng_rst_n) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= e_reg.drv;
        end
    end

    // register store on the serial clock
    isrp_regfile u_regs (
        .scl_clk(scl_pin),
        .rst_n(rst_n),
        .bus(rbus)
    );

    // ---------------- outputs ----------------

    // open drain: only ever pull low
    assign sda_pin_o = w_reg.sda_lo;
    assign sda_pin_oe = oe_reg;
    assign contrast_boost = regs_s[2];
    assign submap_select = regs_s[1:0];
endmodule : isrp_top
`default_nettype wire

// ### isrp_unused_guard.sv
// this file holds no code of the serial register port

// ### isrp_master_model.sv
// bus master model: drives the serial clock and pulls the data wire low
`default_nettype none
module isrp_master_model (
    output var logic scl,
    output var logic sda_oe,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // clock stands high and data released outside frames
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic start();
        #24 sda_oe = 1'b0;
        #24 scl = 1'b1;
        #100 sda_oe = 1'b1;
        #100 scl = 1'b0;
    endtask : start
    task automatic stop();
        #24 sda_oe = 1'b1;
        #24 scl = 1'b1;
        #100 sda_oe = 1'b0;
        #100;
    endtask : stop
    // data moves in low half, released bit means no ack
    task automatic bit_io(input logic b, output logic v);
        #12 sda_oe = !b;
        #12 scl = 1'b1;
        #12 v = sda;
        #12 scl = 1'b0;
    endtask : bit_io
    task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
        output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(mack, a);
    endtask : xfer
endmodule : isrp_master_model
`default_nettype wire

// ### isrp_top_assertions.sv
// port checks of the serial register port
`default_nettype none
module isrp_top_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_pin,
    input wire logic sda_pin_i,
    input wire logic addr_select_pin,
    input wire logic sda_pin_o,
    input wire logic sda_pin_oe,
    input wire logic contrast_boost,
    input wire logic [1:0] submap_select
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic scl_q, sda_q, wr_hit; // last samples, frame writes to us
    logic [3:0] bit_n; // clock rises in the current byte
    logic [1:0] byte_n; // byte of frame, stops at 3 from the second data byte
    logic [7:0] sh, quiet_n; // bits seen, cycles of still clock
    logic slot, adr_slot, sub_slot, hit;
    logic [2:0] outs;
    // ninth rise of a byte, own address in the shifter
    assign slot = scl_pin && !scl_q && bit_n == 4'h8;
    assign adr_slot = slot && byte_n == 2'h0;
    assign sub_slot = slot && byte_n == 2'h1 && wr_hit;
    assign hit = sh[7:1] == {6'h10, addr_select_pin};
    assign outs = {contrast_boost, submap_select};
    // oversample the lines; they are slow next to clk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {scl_q, sda_q, wr_hit, bit_n, byte_n, sh, quiet_n} <= {3'b110, 4'h0, 2'h3, 16'h0};
        end else begin
            scl_q <= scl_pin;
            sda_q <= sda_pin_i;
            quiet_n <= (scl_pin != scl_q) ? 8'h0 : quiet_n + {7'h0, quiet_n != 8'hff};
            if (scl_pin && scl_q && sda_q && !sda_pin_i) begin
                bit_n <= 4'h0;
                byte_n <= 2'h0;
                wr_hit <= 1'b0;
            end else if (scl_pin && !scl_q) begin
                sh <= {sh[6:0], sda_pin_i};
                bit_n <= slot ? 4'h0 : bit_n + 4'h1;
                if (slot && byte_n != 2'h3) byte_n <= byte_n + 2'h1;
                if (adr_slot) wr_hit <= hit && !sh[0];
            end
        end
    end
    chk_addr_ack: assert property (adr_slot && hit |-> sda_pin_oe)
        else $error("no address ack");
    chk_addr_nack: assert property (adr_slot && !hit |-> !sda_pin_oe)
        else $error("foreign address acked");
    chk_sub_ack: assert property (sub_slot && sh < 8'ha0 |-> sda_pin_oe)
        else $error("no subaddress ack");
    chk_sub_nack: assert property (sub_slot && sh > 8'h9f |-> !sda_pin_oe)
        else $error("bad subaddress acked");
    chk_drive_low: assert property (sda_pin_o == 1'b0)
        else $error("data driven high");
    chk_oe_scl_low: assert property ($changed(sda_pin_oe) |-> !scl_pin)
        else $error("data moved with clock high");
    chk_rst_outs: assert property ($rose(rst_n) |-> outs == 3'h0)
        else $error("outputs not cleared");
    chk_regs_quiet: assert property (quiet_n > 8'h10 |-> $stable(outs))
        else $error("outputs moved without traffic");
    chk_idle_release: assert property (quiet_n > 8'h10 |-> !sda_pin_oe)
        else $error("data held while idle");
endmodule : isrp_top_assertions
bind isrp_top isrp_top_assertions chk_u (
    .clk(clk), .rst_n(rst_n), .scl_pin(scl_pin), .sda_pin_i(sda_pin_i),
    .addr_select_pin(addr_select_pin), .sda_pin_o(sda_pin_o), .sda_pin_oe(sda_pin_oe),
    .contrast_boost(contrast_boost), .submap_select(submap_select)
);
`default_nettype wire

// ### isrp_top_test.sv
// self-checking bench of the serial register port
`default_nettype none
module isrp_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string nm; logic [7:0] v;} isrp_note_t;
    logic clk, rst_n, addr_select_pin, s;
    wire scl_pin, m_oe, sda_pin_o, sda_pin_oe, contrast_boost;
    wire [1:0] submap_select;
    // pulled-up data wire, low while either side drives
    wire sda_line = !(m_oe || sda_pin_oe);
    int n_errors = 0;
    int total_checks = 0;
    isrp_note_t notes[$]; // expected results, oldest first
    logic [7:0] got_v, q;
    logic [7:0] r[3];
    event got_ev;
    isrp_top dut_u (.clk(clk), .rst_n(rst_n), .scl_pin(scl_pin), .sda_pin_i(sda_line),
        .addr_select_pin(addr_select_pin), .sda_pin_o(sda_pin_o), .sda_pin_oe(sda_pin_oe),
        .contrast_boost(contrast_boost), .submap_select(submap_select));
    isrp_master_model m_u (.scl(scl_pin), .sda_oe(m_oe), .sda(sda_line));
    initial begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic got(input logic [7:0] v);
        got_v = v;
        ->got_ev;
    endtask : got
    // compare each result with the oldest note
    initial forever begin
        @(got_ev);
        check(notes[0].nm, got_v, notes[0].v);
        void'(notes.pop_front());
    end
    // write frame; bit i of am is the ack expected for byte i
    task automatic wr(input logic [7:0] b[$], input logic [7:0] am);
        m_u.start();
        foreach (b[i]) begin
            notes.push_back('{"ack", {7'h0, am[i]}});
            m_u.xfer(b[i], 1'b1, q, s);
            got({7'h0, !s});
        end
        m_u.stop();
    endtask : wr
    // read frame at own address; master nacks the last byte
    task automatic rd(input logic [7:0] e[$]);
        m_u.start();
        notes.push_back('{"ack", 8'h01});
        m_u.xfer({6'h10, addr_select_pin, 1'b1}, 1'b1, q, s);
        got({7'h0, !s});
        foreach (e[i]) begin
            notes.push_back('{"rdata", e[i]});
            m_u.xfer(8'hff, i == e.size() - 1, q, s);
            got(q);
        end
        m_u.stop();
    endtask : rd
    task automatic outs(input logic [7:0] e);
        repeat (10) @(negedge clk);
        notes.push_back('{"outs", e});
        got({5'h0, contrast_boost, submap_select});
    endtask : outs
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    initial begin
        void'($urandom(32'ha868));
        rst_n = 1'b0;
        addr_select_pin = 1'b0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        outs(8'h00); // cleared by reset
        // map codes 1 and 2, boost on, read back, boost off, home map
        wr({8'h40, 8'h0e, 8'h20}, 8'h07);
        outs(8'h01); // interrupt map
        wr({8'h40, 8'h0e, 8'h40}, 8'h07);
        outs(8'h02); // second map
        wr({8'h40, 8'h80, 8'h80}, 8'h07);
        outs(8'h06); // boost on
        wr({8'h40, 8'h80}, 8'h03);
        rd({8'h80}); // read direction
        wr({8'h40, 8'h80, 8'h00}, 8'h07);
        wr({8'h40, 8'h0e, 8'h00}, 8'h07);
        outs(8'h00); // back home
        $display("test maps done");
        foreach (r[i]) r[i] = 8'($urandom());
        wr({8'h40, 8'h10, r[0], r[1], r[2]}, 8'h1f);
        wr({8'h40, 8'h10}, 8'h03);
        rd({r[0], r[1], r[2]}); // successive registers
        wr({8'h40, 8'h9e, r[0], r[1], r[2]}, 8'h0f); // byte past top refused
        rd({r[1], r[1]}); // top register repeats
        wr({8'h40, 8'ha0, 8'h55}, 8'h01); // bad subaddress
        $display("test pointer done");
        @(negedge clk);
        addr_select_pin = 1'b1;
        wr({8'h40, 8'h0e, 8'h20}, 8'h00); // foreign address
        wr({8'h42, 8'h0e, 8'h20}, 8'h07); // strap moves address
        outs(8'h01);
        $display("test strap done");
        // stray start in mid address byte
        m_u.start();
        for (int i = 0; i < 4; i++) m_u.bit_io(i == 1, s);
        wr({8'h42, 8'h0e, 8'h00}, 8'h07); // restart accepted
        outs(8'h00);
        $display("test restart done");
        final_report();
    end
    // hang guard, well beyond the planned traffic
    initial begin
        #200us;
        n_errors++;
        final_report();
    end
endmodule : isrp_top_test
`default_nettype wire
